// file: epe_pkg.sv
package epe_pkg;

  localparam int NVEC = 48;
  localparam int NIRQ = 32;
  localparam int IRQ_BASE = 16;

  localparam logic [5:0] VEC_SP = 6'h00;
  localparam logic [5:0] VEC_RESET = 6'h01;
  localparam logic [5:0] VEC_NMI = 6'h02;
  localparam logic [5:0] VEC_HARD = 6'h03;
  localparam logic [5:0] VEC_MEM = 6'h04;
  localparam logic [5:0] VEC_BUS = 6'h05;
  localparam logic [5:0] VEC_USAGE = 6'h06;
  localparam logic [5:0] VEC_SVC = 6'h0B;
  localparam logic [5:0] VEC_DBGMON = 6'h0C;
  localparam logic [5:0] VEC_PENDABLE_SERVICE_EXCEPTION = 6'h0E;
  localparam logic [5:0] VEC_TICK = 6'h0F;

  localparam logic [31:0] VT_BASE = 32'h0000_0000;
  localparam logic [31:0] VT_SP_OFF = 32'h0000_0000;
  localparam logic [31:0] VT_RESET_OFF = 32'h0000_0004;
  localparam logic [31:0] VT_NMI_OFF = 32'h0000_0008;

  // Vectors whose priority software may program.
  localparam logic [NVEC-1:0] PROG_MASK = 48'hFFFF_FFFF_D870;
  // Vectors that are always enabled; interrupts and three faults have their own enables.
  localparam logic [NVEC-1:0] FIXED_EN = 48'h0000_0000_D80C;

  localparam logic [3:0] STACK_WORDS = 4'h8;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [31:0] EN_RST = 32'h0000_0000;

  localparam logic [3:0] RANK_RESET = 4'h0;
  localparam logic [3:0] RANK_NMI = 4'h1;
  localparam logic [3:0] RANK_HARD = 4'h2;
  localparam logic [3:0] RANK_PROG = 4'h3;
  localparam logic [3:0] RANK_THREAD = 4'hF;

  typedef enum logic [2:0] {
    S_RST_SP = 3'b000,
    S_RST_PC = 3'b001,
    S_RUN = 3'b011,
    S_STACK = 3'b010,
    S_ENTER = 3'b110,
    S_UNSTACK = 3'b111,
    S_TAIL = 3'b101
  } epe_state_e;

  typedef struct packed {
    epe_state_e st;
    logic [NVEC-1:0] pend;
    logic [NVEC-1:0] act;
    logic [NIRQ-1:0] en;
    logic [NVEC-1:0][2:0] prio;
    logic [5:0] vec;
    logic [3:0] cnt;
    logic vdone;
    logic [31:0] val;
    logic sp_ld;
    logic pc_ld;
    logic hmode;
  } epe_regs_s;

endpackage : epe_pkg

// file: epe_exception_unit.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Entry pushes eight state words; return pops them back.
// - Vector fetch runs alongside the stacking pushes.
// - A pending exception at return chains in without unstack or restack.
// - Eight levels for seven system handlers and 32 interrupts.
// - Priority splits into preemption and subpriority bits.
// - Level 0 ranks after reset, NMI and hard fault; all reset to 0.
// - Four states per exception; requests set pending.
// - A preempted handler stays active beside the preempting one.
// - Reset halts; release resumes privileged thread at reset vector.
// - NMI from pin or software, always enabled, rank -2.
// - Hard fault at -1 for entry errors and unmanageable faults.
// - Memory fault on violation or miss; execute-never always aborts.
// - Bus fault enableable; precise synchronous, imprecise pended.
// - Usage fault causes, plus optional unaligned and divide traps.
// - Supervisor call instruction raises vector 11.
// - Debug monitor only enabled, not halting, and more urgent.
// - Pendable service pends only by software write.
// - Tick pends at timer zero with enable, or by software.
// - Asynchronous entry waits for the next instruction boundary.
// - Reset reads stack pointer at 0x0 and reset handler at 0x4.
// - Configurable exceptions can be disabled by software.
module epe_exception_unit (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [31:0] IRQ_I,
  input wire logic [31:0] IRQ_SW_SET_I,
  input wire logic [31:0] IRQ_EN_SET_I,
  input wire logic [31:0] IRQ_EN_CLR_I,
  input wire logic [2:0] SYS_FAULT_EN_I,
  input wire logic PRI_WE_I,
  input wire logic [5:0] PRI_VEC_I,
  input wire logic [2:0] PRI_VAL_I,
  input wire logic [1:0] PRI_SUBBITS_I,
  input wire logic NMI_I,
  input wire logic NMI_SW_SET_I,
  input wire logic PENDABLE_SERVICE_EXCEPTION_SET_I,
  input wire logic PENDABLE_SERVICE_EXCEPTION_CLR_I,
  input wire logic TICK_SW_SET_I,
  input wire logic TICK_ZERO_I,
  input wire logic TICK_INT_EN_I,
  input wire logic PROT_EN_I,
  input wire logic MEM_VIOL_I,
  input wire logic MEM_MISS_I,
  input wire logic XN_FETCH_I,
  input wire logic BUS_PRECISE_I,
  input wire logic BUS_IMPRECISE_I,
  input wire logic UNDEF_I,
  input wire logic UNALIGN_ILL_I,
  input wire logic INV_STATE_I,
  input wire logic BAD_RETURN_I,
  input wire logic UNALIGN_WH_I,
  input wire logic TRAP_UNALIGN_I,
  input wire logic DIV0_I,
  input wire logic TRAP_DIV0_I,
  input wire logic SVC_EXEC_I,
  input wire logic DBG_MON_REQ_I,
  input wire logic DBG_MON_EN_I,
  input wire logic DBG_HALT_I,
  input wire logic BOUNDARY_I,
  input wire logic EXC_RETURN_I,
  input wire logic STACK_ERR_I,
  input wire logic STACK_ACK_I,
  input wire logic VEC_ACK_I,
  input wire logic [31:0] VEC_DATA_I,
  output logic PUSH_REQ_O,
  output logic POP_REQ_O,
  output logic [2:0] STACK_IDX_O,
  output logic VEC_REQ_O,
  output logic [31:0] VEC_ADDR_O,
  output logic SP_LOAD_O,
  output logic PC_LOAD_O,
  output logic [31:0] LOAD_VAL_O,
  output logic CORE_RUN_O,
  output logic HANDLER_MODE_O,
  output logic PRIV_O,
  output logic [5:0] ACT_VEC_O,
  output logic [47:0] PEND_O,
  output logic [47:0] ACTIVE_O
);

  epe_pkg::epe_regs_s q;
  epe_pkg::epe_regs_s d;
  logic [3:0] rk_full [epe_pkg::NVEC];
  logic [3:0] rk_pre [epe_pkg::NVEC];
  logic [epe_pkg::NVEC-1:0] en_all;
  logic [epe_pkg::NVEC-1:0] set_v;
  logic [epe_pkg::NVEC-1:0] clr_v;
  logic [3:0] exec_rank;
  logic [3:0] ret_rank;
  logic [5:0] cur_vec;
  logic [5:0] best_vec;
  logic [3:0] best_rank;
  logic best_ok;
  logic mm_f;
  logic us_f;

  // Fixed exceptions ignore the stored level; the group mask drops subpriority bits.
  function automatic logic [3:0] rank_of(input logic [5:0] v, input logic [2:0] p,
                                         input logic [1:0] sub, input logic pre);
    logic [2:0] m;
    m = pre ? (p & (3'h7 << sub)) : p;
    case (v)
      epe_pkg::VEC_RESET: rank_of = epe_pkg::RANK_RESET;
      epe_pkg::VEC_NMI: rank_of = epe_pkg::RANK_NMI;
      epe_pkg::VEC_HARD: rank_of = epe_pkg::RANK_HARD;
      default: rank_of = epe_pkg::RANK_PROG + {1'b0, m};
    endcase
  endfunction : rank_of

  for (genvar gi = 0; gi < epe_pkg::NVEC; gi++) begin : g_rank
    assign rk_full[gi] = rank_of(6'(gi), q.prio[gi], PRI_SUBBITS_I, 1'b0);
    assign rk_pre[gi] = rank_of(6'(gi), q.prio[gi], PRI_SUBBITS_I, 1'b1);
  end

  // Only three system faults carry an enable here; the rest are always on.
  assign en_all = {q.en, 9'h000, epe_pkg::FIXED_EN[6:0]}
                  | {41'h0, SYS_FAULT_EN_I, 4'h0}
                  | epe_pkg::FIXED_EN;

  always_comb begin
    exec_rank = epe_pkg::RANK_THREAD;
    cur_vec = epe_pkg::VEC_SP;
    for (int i = 0; i < epe_pkg::NVEC; i++) begin
      if (q.act[i] && rk_pre[i] < exec_rank) begin
        exec_rank = rk_pre[i];
        cur_vec = 6'(i);
      end
    end
    ret_rank = epe_pkg::RANK_THREAD;
    for (int i = 0; i < epe_pkg::NVEC; i++) begin
      if (q.act[i] && 6'(i) != cur_vec && rk_pre[i] < ret_rank) begin
        ret_rank = rk_pre[i];
      end
    end
    best_rank = epe_pkg::RANK_THREAD;
    best_vec = epe_pkg::VEC_SP;
    best_ok = 1'b0;
    for (int i = 0; i < epe_pkg::NVEC; i++) begin
      if (q.pend[i] && en_all[i] && (!best_ok || rk_full[i] < best_rank)) begin
        best_rank = rk_full[i];
        best_vec = 6'(i);
        best_ok = 1'b1;
      end
    end
  end

  always_comb begin
    d = q;
    d.sp_ld = 1'b0;
    d.pc_ld = 1'b0;
    set_v = '0;
    clr_v = '0;
    mm_f = XN_FETCH_I | (PROT_EN_I & (MEM_VIOL_I | MEM_MISS_I));
    us_f = UNDEF_I | UNALIGN_ILL_I | INV_STATE_I | BAD_RETURN_I
           | (TRAP_UNALIGN_I & UNALIGN_WH_I) | (TRAP_DIV0_I & DIV0_I);
    set_v[epe_pkg::NVEC-1:epe_pkg::IRQ_BASE] = IRQ_I | IRQ_SW_SET_I;
    set_v[epe_pkg::VEC_NMI] = NMI_I | NMI_SW_SET_I;
    set_v[epe_pkg::VEC_PENDABLE_SERVICE_EXCEPTION] = PENDABLE_SERVICE_EXCEPTION_SET_I;
    set_v[epe_pkg::VEC_TICK] = (TICK_ZERO_I & TICK_INT_EN_I) | TICK_SW_SET_I;
    set_v[epe_pkg::VEC_SVC] = SVC_EXEC_I;
    set_v[epe_pkg::VEC_BUS] = BUS_IMPRECISE_I;
    // A synchronous fault cannot wait, so one that is disabled or not urgent enough escalates.
    if (mm_f) begin
      if (SYS_FAULT_EN_I[0] && rk_pre[epe_pkg::VEC_MEM] < exec_rank) begin
        set_v[epe_pkg::VEC_MEM] = 1'b1;
      end else begin
        set_v[epe_pkg::VEC_HARD] = 1'b1;
      end
    end
    if (BUS_PRECISE_I) begin
      if (SYS_FAULT_EN_I[1] && rk_pre[epe_pkg::VEC_BUS] < exec_rank) begin
        set_v[epe_pkg::VEC_BUS] = 1'b1;
      end else begin
        set_v[epe_pkg::VEC_HARD] = 1'b1;
      end
    end
    if (us_f) begin
      if (SYS_FAULT_EN_I[2] && rk_pre[epe_pkg::VEC_USAGE] < exec_rank) begin
        set_v[epe_pkg::VEC_USAGE] = 1'b1;
      end else begin
        set_v[epe_pkg::VEC_HARD] = 1'b1;
      end
    end
    if (STACK_ERR_I && (q.st == epe_pkg::S_STACK || q.st == epe_pkg::S_UNSTACK)) begin
      set_v[epe_pkg::VEC_HARD] = 1'b1;
    end
    // A monitor request that could not activate is dropped, not held.
    if (DBG_MON_REQ_I && DBG_MON_EN_I && !DBG_HALT_I
        && rk_pre[epe_pkg::VEC_DBGMON] < exec_rank) begin
      set_v[epe_pkg::VEC_DBGMON] = 1'b1;
    end
    clr_v[epe_pkg::VEC_PENDABLE_SERVICE_EXCEPTION] = PENDABLE_SERVICE_EXCEPTION_CLR_I;
    d.en = (q.en & ~IRQ_EN_CLR_I) | IRQ_EN_SET_I;
    if (PRI_WE_I && PRI_VEC_I < 6'(epe_pkg::NVEC) && epe_pkg::PROG_MASK[PRI_VEC_I]) begin
      d.prio[PRI_VEC_I] = PRI_VAL_I;
    end
    case (q.st)
      epe_pkg::S_RST_SP: begin
        if (VEC_ACK_I) begin
          d.val = VEC_DATA_I;
          d.sp_ld = 1'b1;
          d.st = epe_pkg::S_RST_PC;
        end
      end
      epe_pkg::S_RST_PC: begin
        if (VEC_ACK_I) begin
          d.val = VEC_DATA_I;
          d.pc_ld = 1'b1;
          d.hmode = 1'b0;
          d.st = epe_pkg::S_RUN;
        end
      end
      epe_pkg::S_RUN: begin
        if (q.hmode && EXC_RETURN_I) begin
          d.act[cur_vec] = 1'b0;
          d.cnt = 4'h0;
          d.vdone = 1'b0;
          if (best_ok && rk_pre[best_vec] < ret_rank) begin
            d.vec = best_vec;
            d.st = epe_pkg::S_TAIL;
          end else begin
            d.st = epe_pkg::S_UNSTACK;
          end
        end else if (BOUNDARY_I && best_ok && rk_pre[best_vec] < exec_rank) begin
          d.vec = best_vec;
          d.cnt = 4'h0;
          d.vdone = 1'b0;
          d.st = epe_pkg::S_STACK;
        end
      end
      epe_pkg::S_STACK: begin
        if (STACK_ACK_I && q.cnt != epe_pkg::STACK_WORDS) begin
          d.cnt = q.cnt + 4'h1;
        end
        if (VEC_ACK_I && !q.vdone) begin
          d.val = VEC_DATA_I;
          d.vdone = 1'b1;
        end
        if (q.cnt == epe_pkg::STACK_WORDS && q.vdone) begin
          d.st = epe_pkg::S_ENTER;
        end
      end
      epe_pkg::S_TAIL: begin
        if (VEC_ACK_I) begin
          d.val = VEC_DATA_I;
          d.st = epe_pkg::S_ENTER;
        end
      end
      epe_pkg::S_ENTER: begin
        d.act[q.vec] = 1'b1;
        clr_v[q.vec] = 1'b1;
        d.pc_ld = 1'b1;
        d.hmode = 1'b1;
        d.st = epe_pkg::S_RUN;
      end
      epe_pkg::S_UNSTACK: begin
        if (STACK_ACK_I) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == epe_pkg::STACK_WORDS - 4'h1) begin
            d.hmode = |q.act;
            d.st = epe_pkg::S_RUN;
          end
        end
      end
      default: d.st = epe_pkg::S_RST_SP;
    endcase
    // A request in the same cycle as its clear survives.
    d.pend = (q.pend & ~clr_v) | set_v;
  end

  // The all-zero image is the reset state: first state, no pending, levels at zero.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign PUSH_REQ_O = (q.st == epe_pkg::S_STACK) && (q.cnt != epe_pkg::STACK_WORDS);
  assign POP_REQ_O = (q.st == epe_pkg::S_UNSTACK);
  assign STACK_IDX_O = q.cnt[2:0];
  assign VEC_REQ_O = (q.st == epe_pkg::S_RST_SP) || (q.st == epe_pkg::S_RST_PC)
                     || (q.st == epe_pkg::S_TAIL) || (q.st == epe_pkg::S_STACK && !q.vdone);
  always_comb begin
    case (q.st)
      epe_pkg::S_RST_SP: VEC_ADDR_O = epe_pkg::VT_BASE + epe_pkg::VT_SP_OFF;
      epe_pkg::S_RST_PC: VEC_ADDR_O = epe_pkg::VT_BASE + epe_pkg::VT_RESET_OFF;
      default: VEC_ADDR_O = epe_pkg::VT_BASE + {24'h0, q.vec, 2'b00};
    endcase
  end
  assign SP_LOAD_O = q.sp_ld;
  assign PC_LOAD_O = q.pc_ld;
  assign LOAD_VAL_O = q.val;
  // The core is held off while reset fetches or stacking are under way.
  assign CORE_RUN_O = (q.st == epe_pkg::S_RUN);
  assign HANDLER_MODE_O = q.hmode;
  // Thread mode after reset is always privileged; dropping privilege belongs to the core.
  assign PRIV_O = 1'b1;
  assign ACT_VEC_O = cur_vec;
  assign PEND_O = q.pend;
  assign ACTIVE_O = q.act;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence stack_start_s;
    $past(q.st) == epe_pkg::S_RUN && q.st == epe_pkg::S_STACK;
  endsequence

  sequence enter_from_stack_s;
    q.st == epe_pkg::S_ENTER && $past(q.st) == epe_pkg::S_STACK;
  endsequence

  AST_STACK_FULL: assert property (enter_from_stack_s |->
    $past(q.cnt) == epe_pkg::STACK_WORDS) else $error("entry before all pushes");
  AST_VEC_PARALLEL: assert property (stack_start_s |->
    VEC_REQ_O && PUSH_REQ_O && STACK_IDX_O == 3'h0) else $error("fetch not alongside push");
  AST_TAIL_NO_STACK: assert property (q.st == epe_pkg::S_TAIL |->
    !PUSH_REQ_O && !POP_REQ_O) else $error("stack traffic in tail chain");
  AST_PRIO_WRITE: assert property (PRI_WE_I && PRI_VEC_I == 6'h10 |=>
    q.prio[16] == $past(PRI_VAL_I)) else $error("priority write lost");
  AST_GROUP_MASK: assert property (PRI_SUBBITS_I == 2'h2 && q.prio[16] == 3'h3 |->
    rk_pre[16] == epe_pkg::RANK_PROG && rk_full[16] == epe_pkg::RANK_PROG + 4'h3)
    else $error("subpriority leaked into preemption");
  AST_HARD_RANK: assert property (rk_full[3] == epe_pkg::RANK_HARD
    && rk_full[16] > rk_full[3]) else $error("hard fault not above programmable");
  AST_PEND_SET: assert property (IRQ_I[0] |=> q.pend[16])
    else $error("request did not pend");
  AST_ENTER_ACTIVE: assert property (q.st == epe_pkg::S_ENTER |=>
    q.act[$past(q.vec)] && (($past(q.act) & ~q.act) == '0)) else $error("active bit lost");
  AST_NMI_PEND: assert property (NMI_SW_SET_I |=> q.pend[2])
    else $error("nmi not pended");
  AST_DBG_HALT: assert property (DBG_HALT_I && !q.pend[12] |=> !q.pend[12])
    else $error("monitor pended while halted");
  AST_PREEMPT_STRICT: assert property (stack_start_s |->
    rk_pre[q.vec] < $past(exec_rank)) else $error("preempt not strictly higher");
  AST_RESET_SEQ: assert property (SP_LOAD_O |-> q.st == epe_pkg::S_RST_PC ##1
    VEC_ADDR_O == epe_pkg::VT_RESET_OFF || PC_LOAD_O) else $error("reset fetch order");
  AST_VEC_ADDR: assert property (q.st == epe_pkg::S_TAIL |->
    VEC_ADDR_O == {24'h0, q.vec, 2'b00}) else $error("vector address wrong");

endmodule : epe_exception_unit

// file: epe_core_model.sv
`timescale 1ns/1ps

// Core and memory side: answers stack words, every other cycle when slow, and vector reads, always every other cycle.
module epe_core_model #(
  parameter logic [31:0] KEY = 32'hA5A5_0001
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic push_req_i,
  input wire logic pop_req_i,
  input wire logic vec_req_i,
  input wire logic [31:0] vec_addr_i,
  output logic stack_ack_o,
  output logic vec_ack_o,
  output logic [31:0] vec_data_o
);
  // A released data bus flips every cycle, so a stale word can never pass for an answer.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_ack_o <= 1'b0;
      vec_ack_o <= 1'b0;
      vec_data_o <= 32'hFFFF_FFFF;
    end else begin
      stack_ack_o <= (push_req_i || pop_req_i) && !(slow_i && stack_ack_o);
      vec_ack_o <= vec_req_i && !vec_ack_o;
      vec_data_o <= (vec_req_i && !vec_ack_o) ? (vec_addr_i ^ KEY) : ~vec_data_o;
    end
  end
endmodule : epe_core_model

// file: epe_exception_unit_tb.sv
`timescale 1ns/1ps

module epe_exception_unit_tb;
  typedef struct packed {
    logic [18:0] ev;
    logic [5:0] vec;
  } epe_row_s;
  localparam logic [31:0] KEY = 32'hA5A5_0001;
  logic clk = 0, rst_n = 0, bnd = 1, ret = 0, slow = 0, pri_we = 0, halt = 0;
  logic [18:0] ev = '0;
  logic [6:0] cfg = 7'h7F;
  logic [31:0] irq = '0, irq_sw = '0, en_set = '0, en_clr = '0;
  logic [5:0] pri_vec = '0;
  logic [2:0] pri_val = '0;
  logic [1:0] sub = '0;
  logic push, pop, vreq, sack, vack, spl, pcl, run, hm, priv;
  logic [2:0] idx;
  logic [31:0] vaddr, vdata, lval;
  logic [5:0] actv;
  logic [47:0] pend, act;
  int fail_count = 0, checks = 0, pushes = 0, pops = 0, overlap = 0;
  epe_row_s rows [18] = '{'{19'h00001, 6'h02}, '{19'h00002, 6'h02}, '{19'h00004, 6'h0E},
    '{19'h00008, 6'h0F}, '{19'h00010, 6'h0F}, '{19'h00020, 6'h0B}, '{19'h00040, 6'h0C},
    '{19'h00080, 6'h04}, '{19'h00100, 6'h05}, '{19'h00200, 6'h06}, '{19'h00400, 6'h06},
    '{19'h00800, 6'h05}, '{19'h41000, 6'h04}, '{19'h42000, 6'h04}, '{19'h04000, 6'h06},
    '{19'h08000, 6'h06}, '{19'h10000, 6'h06}, '{19'h20000, 6'h06}};

  epe_exception_unit epe_exception_unit_inst (.CLK_I(clk), .RST_N_I(rst_n), .IRQ_I(irq),
    .IRQ_SW_SET_I(irq_sw), .IRQ_EN_SET_I(en_set), .IRQ_EN_CLR_I(en_clr),
    .SYS_FAULT_EN_I(cfg[2:0]), .PRI_WE_I(pri_we), .PRI_VEC_I(pri_vec), .PRI_VAL_I(pri_val),
    .PRI_SUBBITS_I(sub), .NMI_I(ev[0]), .NMI_SW_SET_I(ev[1]), .PENDABLE_SERVICE_EXCEPTION_SET_I(ev[2]),
    .PENDABLE_SERVICE_EXCEPTION_CLR_I(1'b0), .TICK_SW_SET_I(ev[3]), .TICK_ZERO_I(ev[4]), .TICK_INT_EN_I(cfg[4]),
    .PROT_EN_I(ev[18]), .MEM_VIOL_I(ev[12]), .MEM_MISS_I(ev[13]), .XN_FETCH_I(ev[7]),
    .BUS_PRECISE_I(ev[11]), .BUS_IMPRECISE_I(ev[8]), .UNDEF_I(ev[9]), .UNALIGN_ILL_I(ev[14]),
    .INV_STATE_I(ev[15]), .BAD_RETURN_I(ev[16]), .UNALIGN_WH_I(ev[17]),
    .TRAP_UNALIGN_I(cfg[5]), .DIV0_I(ev[10]), .TRAP_DIV0_I(cfg[6]), .SVC_EXEC_I(ev[5]),
    .DBG_MON_REQ_I(ev[6]), .DBG_MON_EN_I(cfg[3]), .DBG_HALT_I(halt), .BOUNDARY_I(bnd),
    .EXC_RETURN_I(ret), .STACK_ERR_I(1'b0), .STACK_ACK_I(sack), .VEC_ACK_I(vack),
    .VEC_DATA_I(vdata), .PUSH_REQ_O(push), .POP_REQ_O(pop), .STACK_IDX_O(idx),
    .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr), .SP_LOAD_O(spl), .PC_LOAD_O(pcl),
    .LOAD_VAL_O(lval), .CORE_RUN_O(run), .HANDLER_MODE_O(hm), .PRIV_O(priv),
    .ACT_VEC_O(actv), .PEND_O(pend), .ACTIVE_O(act));

  epe_core_model #(.KEY(KEY)) epe_core_model_inst (.clk_i(clk), .rst_n_i(rst_n),
    .slow_i(slow), .push_req_i(push), .pop_req_i(pop), .vec_req_i(vreq),
    .vec_addr_i(vaddr), .stack_ack_o(sack), .vec_ack_o(vack), .vec_data_o(vdata));

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (push && sack) pushes = pushes + 1;
    if (pop && sack) pops = pops + 1;
    if (push && vreq) overlap = 1;
  end

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic fire(input logic [18:0] e);
    pushes = 0;
    pops = 0;
    overlap = 0;
    ev = e;
    @(negedge clk);
    ev = '0;
  endtask : fire

  task automatic enter(input logic [5:0] v, input int pex);
    int n;
    n = 0;
    while (pcl !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("vector", {26'h0, v, 2'b00} ^ KEY, lval);
    chk("act_vec", v, actv);
    chk("hmode", 1, hm);
    chk("words", pex, pushes + pops);
    if (pex == 8) chk("overlap", 1, overlap);
  endtask : enter

  task automatic give_back();
    pushes = 0;
    pops = 0;
    ret = 1;
    @(negedge clk);
    ret = 0;
  endtask : give_back

  task automatic leave();
    int n;
    n = 0;
    give_back();
    while (run !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("pops", 8, pops);
    pushes = 0;
    pops = 0;
    overlap = 0;
  endtask : leave

  task automatic do_reset();
    int n;
    n = 0;
    rst_n = 0;
    repeat (12) @(negedge clk);
    chk("rst_addr", 0, vaddr);
    chk("rst_run", 0, run);
    rst_n = 1;
    while (spl !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("sp", KEY, lval);
    while (pcl !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("reset_pc", 32'h0000_0004 ^ KEY, lval);
    @(negedge clk);
    chk("thread", 3'b101, {run, hm, priv});
  endtask : do_reset

  initial begin
    #(25 * 20000);
    fail_count++;
    end_of_test();
  end

  initial begin
    @(negedge clk);
    do_reset();
    foreach (rows[i]) begin
      fire(rows[i].ev);
      enter(rows[i].vec, 8);
      leave();
      chk("idle", 96'h0, {pend, act});
    end
    // A disabled interrupt stays pending and is only taken once enabled.
    irq_sw[3] = 1;
    @(negedge clk);
    irq_sw[3] = 0;
    repeat (20) @(negedge clk);
    chk("held", 50'h2_0000_0008_0000, {run, hm, pend});
    en_set[3] = 1;
    @(negedge clk);
    en_set[3] = 0;
    enter(6'h13, 8);
    leave();
    cfg[1] = 0;
    fire(19'h00800);
    enter(6'h03, 8);
    leave();
    cfg = 7'h77;
    fire(19'h00040);
    repeat (10) @(negedge clk);
    chk("dbg_off", 0, pend[12] | act[12]);
    cfg = 7'h7F;
    halt = 1;
    fire(19'h00040);
    repeat (5) @(negedge clk);
    chk("dbg_halt", 0, pend[12] | act[12]);
    halt = 0;
    bnd = 0;
    slow = 1;
    fire(19'h00004);
    repeat (10) @(negedge clk);
    chk("no_entry", 2'b11, {run, pend[14]});
    bnd = 1;
    enter(6'h0E, 8);
    leave();
    // Grouping: with two subpriority bits, level 3 and level 0 share one preemption group.
    pri_vec = 6'h10;
    pri_val = 3'h3;
    pri_we = 1;
    sub = 2'h2;
    en_set[0] = 1;
    @(negedge clk);
    {pri_we, en_set[0]} = 2'b00;
    irq[0] = 1;
    enter(6'h10, 8);
    irq[0] = 0;
    chk("act_pend", 2'b11, {pend[16], act[16]});
    fire(19'h00004);
    repeat (20) @(negedge clk);
    chk("no_preempt", 7'h50, {run, actv});
    fire(19'h00001);
    enter(6'h02, 8);
    chk("nested", 2'b11, {act[2], act[16]});
    leave();
    chk("resumed", 7'h50, {hm, actv});
    give_back();
    enter(6'h0E, 0);
    give_back();
    enter(6'h10, 0);
    leave();
    // An enable cleared in the same cycle as a request keeps it pending and untaken.
    en_clr[0] = 1;
    irq_sw[0] = 1;
    @(negedge clk);
    en_clr[0] = 0;
    irq_sw[0] = 0;
    repeat (10) @(negedge clk);
    chk("disabled", 3'b101, {run, hm, pend[16]});
    fire(19'h00020);
    repeat (3) @(negedge clk);
    do_reset();
    end_of_test();
  end
endmodule : epe_exception_unit_tb
